/* include/pp_gate_pkg.sv */
// Constants and carrier types for the push-pull gate drive logic
package pp_gate_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int REF_PERIOD_NS      = 5;
    localparam int CLK_TIMEOUT_MIN_NS = 10000;
    localparam int CLK_TIMEOUT_MAX_NS = 25000;
    // Aim mid-window so sync latency and jitter stay inside both bounds
    localparam int CLK_TIMEOUT_CYC    =
        ((CLK_TIMEOUT_MIN_NS + CLK_TIMEOUT_MAX_NS) / 2) / REF_PERIOD_NS;

    localparam int FSW_A_KHZ      = 160;
    localparam int FSW_B_KHZ      = 440;
    // Oscillator runs at twice the switching rate; divider halves it
    localparam int OSC_TICK_A_CYC = 1000000 / (2 * FSW_A_KHZ * REF_PERIOD_NS);
    localparam int OSC_TICK_B_CYC = 1000000 / (2 * FSW_B_KHZ * REF_PERIOD_NS);

    localparam int DEAD_A_NS  = 128;
    localparam int DEAD_B_NS  = 90;
    localparam int DEAD_A_CYC = (DEAD_A_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    localparam int DEAD_B_CYC = (DEAD_B_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

    localparam int SS_RAMP_US     = 5000;
    localparam int SS_DELAY_US    = 8500;
    localparam int RAMP_LEVELS    = 256;
    localparam int RAMP_SHIFT     = 4;
    localparam int SS_HOLD_CYC    =
        (SS_DELAY_US - SS_RAMP_US) * 1000 / REF_PERIOD_NS;
    localparam int SS_STEP_CYC    =
        SS_RAMP_US * 1000 / REF_PERIOD_NS / RAMP_LEVELS;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int TICK_W    = 10;
    localparam int DEAD_W    = 5;
    localparam int GAP_W     = 6;
    localparam int ON_W      = 12;
    localparam int TIMEOUT_W = 12;
    localparam int HOLD_W    = 20;
    localparam int STEP_W    = 12;
    localparam int LEVEL_W   = 8;
    localparam logic PHASE_A_RST = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic phase_a_square;
        logic phase_b_square;
    } phase_pair_t;

    typedef struct packed {
        logic gate_drive_a;
        logic gate_drive_b;
    } gate_pair_t;

    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_HOLD = 2'b01,
        ST_RAMP = 2'b11,
        ST_RUN  = 2'b10
    } ss_state_t;

endpackage : pp_gate_pkg

/* hw/ext_clk_monitor.sv */
// External clock synchroniser, edge detector and loss-of-clock timeout
`timescale 1ns/1ps
module ext_clk_monitor
    import pp_gate_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic ext_clk,
    output logic      ext_tick,
    output logic      ext_active
);
    import pp_gate_pkg::*;

    logic [1:0]           sync_reg;
    logic                 prev_reg;
    logic                 edge_w;
    logic [TIMEOUT_W-1:0] idle_reg;
    logic                 active_reg;
    logic                 tick_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sync_reg <= 2'h0;
            prev_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[0], ext_clk};
            prev_reg <= sync_reg[1];
        end
    end

    assign edge_w = sync_reg[1] & ~prev_reg;

    // ------------------------------------------------------------
    // Validity timeout
    // ------------------------------------------------------------
    // loss-of-clock timeout
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            idle_reg   <= '0;
            active_reg <= 1'b0;
        end else if (edge_w) begin
            idle_reg   <= '0;
            active_reg <= 1'b1;
        end else if (active_reg) begin
            if (idle_reg == TIMEOUT_W'(CLK_TIMEOUT_CYC - 1)) begin
                active_reg <= 1'b0;
            end else begin
                idle_reg <= idle_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= edge_w;
        end
    end

    assign ext_tick   = tick_reg;
    assign ext_active = active_reg;

    a_timeout_exact: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(active_reg) |->
            $past(idle_reg) == TIMEOUT_W'(CLK_TIMEOUT_CYC - 1))
        else $error("External clock dropped at wrong idle count");

    a_edge_revives: assert property (@(posedge ref_clk) disable iff (!rst_b)
        edge_w |=> active_reg && idle_reg == '0 && tick_reg)
        else $error("External edge did not mark clock active");

endmodule : ext_clk_monitor

/* hw/push_pull_gate_drive_logic.sv */
// Push-pull gate drive: clock select, divider, dead time, soft start
`timescale 1ns/1ps
// Function
// - lost external clock falls back to internal oscillator within 10-25 us.
// - selected oscillator divided into two complementary 50% phase squares.
// - dead-time stage after divider gaps the high pulses of both phases.
// - a gate may rise only while both gates are low.
// - dead gap is 128 ns on low-frequency, 90 ns on high-frequency variant.
// - gates alternate so one switch conducts per half period.
// - soft-start ramps drive over about 5 ms.
// - start-up delay to full drive about 8.5 ms.
// - both phases get identical average on-time.
module push_pull_gate_drive_logic
    import pp_gate_pkg::*;
#(
    parameter bit HF_VARIANT     = 1'b0,
    parameter int SS_HOLD_CYCLES = SS_HOLD_CYC,
    parameter int SS_STEP_CYCLES = SS_STEP_CYC
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic                en,
    input  wire logic                ext_clk,
    output pp_gate_pkg::phase_pair_t phase_square,
    output pp_gate_pkg::gate_pair_t  gate_drive,
    output logic                     ext_clk_active
);
    import pp_gate_pkg::*;

    localparam logic [TICK_W-1:0] OSC_TICK_SEL = HF_VARIANT ?
        TICK_W'(OSC_TICK_B_CYC - 1) : TICK_W'(OSC_TICK_A_CYC - 1);
    localparam logic [DEAD_W-1:0] DEAD_SEL = HF_VARIANT ?
        DEAD_W'(DEAD_B_CYC) : DEAD_W'(DEAD_A_CYC);

    function automatic logic is_running(input ss_state_t st);
        return (st == ST_RAMP) || (st == ST_RUN);
    endfunction : is_running

    logic [1:0]         en_sync_reg;
    ss_state_t          state_reg;
    logic [HOLD_W-1:0]  hold_reg;
    logic [STEP_W-1:0]  step_reg;
    logic [LEVEL_W-1:0] level_reg;
    logic [TICK_W-1:0]  osc_reg;
    logic               int_tick;
    logic               ext_tick;
    logic               tick;
    logic               run;
    phase_pair_t        phase_reg;
    gate_pair_t         gate_reg;
    logic [DEAD_W-1:0]  dead_reg;
    logic [ON_W-1:0]    on_reg;
    logic [ON_W-1:0]    ramp_limit;
    logic               cap_ok;
    logic [GAP_W-1:0]   gap_reg;

    // ------------------------------------------------------------
    // Enable synchroniser and clock source
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            en_sync_reg <= 2'h0;
        end else begin
            en_sync_reg <= {en_sync_reg[0], en};
        end
    end

    ext_clk_monitor u_ext_mon (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .ext_clk    (ext_clk),
        .ext_tick   (ext_tick),
        .ext_active (ext_clk_active)
    );

    // Internal oscillator runs always so fallback needs no start-up
    always_ff @(posedge ref_clk) begin
        if (!rst_b || osc_reg == OSC_TICK_SEL) begin
            osc_reg <= '0;
        end else begin
            osc_reg <= osc_reg + 1'b1;
        end
    end

    assign int_tick = (osc_reg == OSC_TICK_SEL);
    // fallback once the monitor drops the clock
    assign tick = ext_clk_active ? ext_tick : int_tick;

    // ------------------------------------------------------------
    // Soft-start sequencer
    // ------------------------------------------------------------
    // hold then ramp
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !en_sync_reg[1]) begin
            state_reg <= ST_OFF;
            hold_reg  <= '0;
            step_reg  <= '0;
            level_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_OFF: begin
                    state_reg <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (hold_reg == HOLD_W'(SS_HOLD_CYCLES - 1)) begin
                        state_reg <= ST_RAMP;
                    end else begin
                        hold_reg <= hold_reg + 1'b1;
                    end
                end
                // level climbs one step per step period
                ST_RAMP: begin
                    if (step_reg == STEP_W'(SS_STEP_CYCLES - 1)) begin
                        step_reg <= '0;
                        if (level_reg == LEVEL_W'(RAMP_LEVELS - 1)) begin
                            state_reg <= ST_RUN;
                        end else begin
                            level_reg <= level_reg + 1'b1;
                        end
                    end else begin
                        step_reg <= step_reg + 1'b1;
                    end
                end
                ST_RUN: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    assign run        = is_running(state_reg);
    assign ramp_limit = {level_reg, {RAMP_SHIFT{1'b1}}};
    // Pulse width cap per half period; lifted once ramp completes
    assign cap_ok     = (state_reg == ST_RUN) || (on_reg < ramp_limit);

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // toggle per oscillator tick, complementary pair
    // held in initial state when not running
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !run) begin
            phase_reg.phase_a_square <= PHASE_A_RST;
            phase_reg.phase_b_square <= ~PHASE_A_RST;
        end else if (tick) begin
            phase_reg.phase_a_square <= ~phase_reg.phase_a_square;
            phase_reg.phase_b_square <= phase_reg.phase_a_square;
        end
    end

    // ------------------------------------------------------------
    // Break-before-make
    // ------------------------------------------------------------
    // dead gap after every phase edge
    // same gap and cap for both phases
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !run) begin
            gate_reg <= '0;
            dead_reg <= DEAD_SEL;
            on_reg   <= '0;
        end else if (tick) begin
            gate_reg <= '0;
            dead_reg <= DEAD_SEL;
            on_reg   <= '0;
        end else if (dead_reg != '0) begin
            gate_reg <= '0;
            dead_reg <= dead_reg - 1'b1;
        end else if (cap_ok) begin
            // only the gate of the high phase conducts
            gate_reg.gate_drive_a <= phase_reg.phase_a_square &
                                     ~gate_reg.gate_drive_b;
            gate_reg.gate_drive_b <= phase_reg.phase_b_square &
                                     ~gate_reg.gate_drive_a;
            if (on_reg != {ON_W{1'b1}}) begin
                on_reg <= on_reg + 1'b1;
            end
        end else begin
            gate_reg <= '0;
        end
    end

    assign phase_square = phase_reg;
    assign gate_drive   = gate_reg;

    // Cycles both gates have been low, saturating; checks only
    always_ff @(posedge ref_clk) begin
        if (!rst_b || gate_reg.gate_drive_a || gate_reg.gate_drive_b) begin
            gap_reg <= '0;
        end else if (gap_reg != {GAP_W{1'b1}}) begin
            gap_reg <= gap_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    a_no_overlap: assert property (
        !(gate_drive.gate_drive_a && gate_drive.gate_drive_b))
        else $error("Both gates high together");

    a_dead_gap_a: assert property (
        $rose(gate_drive.gate_drive_a) |->
            $past(gap_reg) >= GAP_W'(DEAD_SEL))
        else $error("Gate A rose before dead gap expired");

    a_dead_gap_b: assert property (
        $rose(gate_drive.gate_drive_b) |->
            $past(gap_reg) >= GAP_W'(DEAD_SEL))
        else $error("Gate B rose before dead gap expired");

    a_gate_phase: assert property (
        (gate_drive.gate_drive_a |-> phase_square.phase_a_square) and
        (gate_drive.gate_drive_b |-> phase_square.phase_b_square))
        else $error("Gate drives against its phase");

    a_div_tick: assert property (
        $changed(phase_square.phase_a_square) |->
            ($past(tick) || $past(!run)) &&
            phase_square.phase_b_square == !phase_square.phase_a_square)
        else $error("Divider moved without a tick");

    a_idle_hold: assert property (
        !run |=> gate_drive == '0 &&
            phase_square.phase_a_square == PHASE_A_RST)
        else $error("Outputs not idle while stopped");

    a_ext_drives: assert property (
        run && ext_clk_active && ext_tick |=>
            $changed(phase_square.phase_a_square))
        else $error("External tick did not step divider");

    a_ramp_cap: assert property (
        state_reg == ST_RAMP && (gate_drive.gate_drive_a ||
            gate_drive.gate_drive_b) |-> on_reg <= ramp_limit)
        else $error("On-time exceeds soft-start cap");

    a_hold_off: assert property (
        state_reg == ST_HOLD || state_reg == ST_OFF |=>
            gate_drive == '0 [*2])
        else $error("Gate driven during start-up hold");

endmodule : push_pull_gate_drive_logic

/* tb/xfmr_primary_model.sv */
// Behavioural primary winding and power switches on the far side
`timescale 1ns/1ps
module xfmr_primary_model (
    input  wire logic                 ref_clk,
    input  pp_gate_pkg::gate_pair_t   gate_drive,
    output logic                      switch_out_a,
    output logic                      switch_out_b,
    output logic                      shorted
);
    import pp_gate_pkg::*;

    // Drain rests at centre-tap level; a conducting switch pulls it low
    assign switch_out_a = ~gate_drive.gate_drive_a;
    assign switch_out_b = ~gate_drive.gate_drive_b;

    always_ff @(posedge ref_clk) begin
        shorted <= ~switch_out_a & ~switch_out_b;
    end
endmodule : xfmr_primary_model

/* tb/gap_meter.sv */
// Measures dead gaps, on-times and alternation of one gate pair
`timescale 1ns/1ps
module gap_meter (
    input  wire logic                 ref_clk,
    input  pp_gate_pkg::gate_pair_t   g,
    output int                        gap,
    output int                        on_a,
    output int                        on_b,
    output int                        same_twice
);
    import pp_gate_pkg::*;
    int         run;
    int         on;
    gate_pair_t last;

    initial begin
        {gap, on_a, on_b, same_twice, run, on} = '0;
        last = 2'b00;
    end

    always @(posedge ref_clk) begin
        if (g === 2'b00) begin
            run <= run + 1;
            if (on != 0 && last.gate_drive_a) on_a <= on;
            if (on != 0 && last.gate_drive_b) on_b <= on;
            on <= 0;
        end else begin
            // Only a rise after an earlier conduction of either gate counts as a dead gap
            if (run != 0 && last != 2'b00) begin
                gap <= run;
                if (g == last) same_twice <= same_twice + 1;
            end
            run <= 0;
            on <= on + 1;
            last <= g;
        end
    end
endmodule : gap_meter

/* tb/testbench.sv */
// Self-checking bench for the push-pull gate drive logic
`timescale 1ns/1ps
module testbench;
    import pp_gate_pkg::*;
    // ----------------------------------------------------------------
    // Setup
    // ----------------------------------------------------------------
    localparam int HOLD = 50;
    localparam int STEP = 4;
    localparam int TICK = OSC_TICK_A_CYC;
    localparam int DEAD = DEAD_A_CYC;
    logic        ref_clk, rst_b, en, ext_clk;
    logic        ext_clk_active, switch_out_a, switch_out_b, shorted;
    phase_pair_t phase_square;
    gate_pair_t  gate_drive, gate_hf;
    int          mismatches, compares;
    int          gap_lf, on_a_lf, on_b_lf, twice_lf;
    int          gap_hf, on_a_hf, on_b_hf, twice_hf;

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    push_pull_gate_drive_logic #(.HF_VARIANT(1'b0),
        .SS_HOLD_CYCLES(HOLD), .SS_STEP_CYCLES(STEP)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .en(en), .ext_clk(ext_clk),
        .phase_square(phase_square), .gate_drive(gate_drive),
        .ext_clk_active(ext_clk_active));
    // Second variant shares all inputs so both dead times are seen
    push_pull_gate_drive_logic #(.HF_VARIANT(1'b1),
        .SS_HOLD_CYCLES(HOLD), .SS_STEP_CYCLES(STEP)) i_dut_hf (
        .ref_clk(ref_clk), .rst_b(rst_b), .en(en), .ext_clk(ext_clk),
        .phase_square(), .gate_drive(gate_hf), .ext_clk_active());
    xfmr_primary_model i_load (.ref_clk(ref_clk), .gate_drive(gate_drive),
        .switch_out_a(switch_out_a), .switch_out_b(switch_out_b),
        .shorted(shorted));
    gap_meter i_gap_lf (.ref_clk(ref_clk), .g(gate_drive), .gap(gap_lf),
        .on_a(on_a_lf), .on_b(on_b_lf), .same_twice(twice_lf));
    gap_meter i_gap_hf (.ref_clk(ref_clk), .g(gate_hf), .gap(gap_hf),
        .on_a(on_a_hf), .on_b(on_b_hf), .same_twice(twice_hf));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            mismatches++;
            $display("ERROR t=%0t %s", $time, msg);
        end
    endtask : check

    task automatic complete_run;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic timed_out;
        mismatches++;
        $display("ERROR t=%0t wait limit used up", $time);
        complete_run();
    endtask : timed_out

    // Cycles until the A phase square changes level
    task automatic wait_toggle(input int bound, output int n);
        logic p;
        p = phase_square.phase_a_square;
        n = 0;
        while (phase_square.phase_a_square === p) begin
            cyc(1);
            n++;
            if (n > bound) timed_out();
        end
    endtask : wait_toggle

    // Cycles until some gate conducts
    task automatic wait_gate(input int bound, output int n);
        n = 0;
        while (gate_drive === 2'b00) begin
            cyc(1);
            n++;
            if (n > bound) timed_out();
        end
    endtask : wait_gate

    // Overlap and complement watched on every cycle out of reset
    always @(negedge ref_clk) begin
        if (rst_b === 1'b1) begin
            check(shorted === 1'b0, "both switches conduct");
            check(gate_hf !== 2'b11, "hf gates overlap");
            check(phase_square.phase_a_square !==
                  phase_square.phase_b_square, "phases equal");
        end
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset;
        check(gate_drive === 2'b00, "gates on in reset");
        check(phase_square === 2'b01, "divider not initial");
        check(ext_clk_active === 1'b0, "ext clock valid in reset");
        check(switch_out_a === 1'b1 && switch_out_b === 1'b1,
              "switch conducts in reset");
        $display("test_reset done");
    endtask : test_reset

    task automatic test_startup;
        int n;
        cyc(40);
        check(gate_drive === 2'b00, "gates on while disabled");
        @(posedge ref_clk);
        en <= 1'b1;
        wait_gate(HOLD + TICK + DEAD + 20, n);
        check(n >= HOLD + DEAD && n <= HOLD + DEAD + 6,
              "gates off hold plus dead time");
        check(gate_drive === 2'b01, "first conduction not b");
        cyc(RAMP_LEVELS * STEP + 2 * TICK);
        $display("test_startup done");
    endtask : test_startup

    task automatic test_dead_time;
        int n;
        cyc(6 * TICK);
        check(gap_lf >= DEAD && gap_lf <= DEAD + 2, "lf dead gap");
        check(gap_hf >= DEAD_B_CYC && gap_hf <= DEAD_B_CYC + 2,
              "hf dead gap");
        check(twice_lf == 0 && twice_hf == 0, "gates not alternating");
        check(on_a_lf == on_b_lf && on_a_hf == on_b_hf, "on-time skew");
        check(on_a_lf >= TICK - DEAD - 3 && on_a_lf <= TICK - DEAD,
              "on-time not half period less gap");
        wait_toggle(TICK + 5, n);
        wait_toggle(TICK + 5, n);
        check(n >= TICK - 1 && n <= TICK + 1, "half period");
        $display("test_dead_time done");
    endtask : test_dead_time

    task automatic test_ext_clock;
        int   n;
        logic p;
        for (int k = 0; k < 4; k++) begin
            p = phase_square.phase_a_square;
            @(posedge ref_clk);
            ext_clk <= 1'b1;
            cyc(8);
            check(ext_clk_active === 1'b1, "ext clock not valid");
            check(phase_square.phase_a_square !== p, "no ext step");
            p = phase_square.phase_a_square;
            cyc(190);
            @(posedge ref_clk);
            ext_clk <= 1'b0;
            cyc(199);
            check(phase_square.phase_a_square === p, "internal tick");
        end
        n = 0;
        while (ext_clk_active === 1'b1) begin
            cyc(1);
            n++;
            if (n > 6000) timed_out();
        end
        check(n + 399 >= 2000 && n + 399 <= 5000, "fallback timeout");
        wait_toggle(TICK + 5, n);
        wait_toggle(TICK + 5, n);
        check(n >= TICK - 1 && n <= TICK + 1, "no internal fallback");
        $display("test_ext_clock done");
    endtask : test_ext_clock

    task automatic test_disable;
        int n;
        int bad;
        @(posedge ref_clk);
        en <= 1'b0;
        // Two sync stages, one cycle to OFF, one more to clear outputs
        cyc(5);
        bad = 0;
        repeat (700) begin
            if (gate_drive !== 2'b00 || phase_square !== 2'b01) bad++;
            cyc(1);
        end
        check(bad == 0, "output or divider active when off");
        @(posedge ref_clk);
        en <= 1'b1;
        wait_gate(HOLD + TICK + DEAD + 20, n);
        check(n >= HOLD + DEAD && n <= HOLD + DEAD + 6,
              "restart skipped hold");
        $display("test_disable done");
    endtask : test_disable

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        mismatches = 0;
        compares = 0;
        rst_b = 1'b0;
        en = 1'b0;
        ext_clk = 1'b0;
        cyc(5);
        test_reset();
        @(posedge ref_clk);
        rst_b <= 1'b1;
        test_startup();
        test_dead_time();
        test_ext_clock();
        test_disable();
        complete_run();
    end
endmodule : testbench
